// file: design/sfp_flash_top.sv
// Serial flash command front end, protection logic, OTP space and program engine with an APB view.
// Assumes SPI pins are asynchronous to sys_clk and the serial clock is slow enough for 2-stage sampling.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sfp_flash_top #(
  parameter int         DENSITY     = sfp_pkg::DENS_LARGE,
  parameter int         MAIN_AW     = 12,
  parameter logic [7:0] OTP_PROG_OP = 8'h42,
  parameter logic [7:0] OTP_READ_OP = 8'h4B,
  // Arbitrary value
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89AB_CDEF
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  sfp_pkg::sfp_spi_in_t spi_in,
  output logic                spi_so,
  output logic                spi_so_oe,
  input  sfp_pkg::sfp_apb_req_t apb_req,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr
);
  import sfp_pkg::*;

  localparam int          AW        = (DENSITY == DENS_SMALL) ? ADDR_W_SMALL :
                                      (DENSITY == DENS_MID)   ? ADDR_W_MID : ADDR_W_LARGE;
  localparam logic [23:0] ADDR_MASK = 24'((1 << AW) - 1);
  localparam int          OTP_DEPTH = 512;

  function automatic logic otp_in_range(input logic [23:0] a);
    otp_in_range = (a >= OTP_BASE) && (a <= OTP_TOP);
  endfunction

  function automatic logic [8:0] otp_index(input logic [23:0] a);
    logic [23:0] d;
    d = a - OTP_BASE;
    otp_index = d[8:0];
  endfunction

  // Lock bits are active low: a programmed (zero) bit locks its segment
  function automatic logic otp_locked(input logic [23:0] a, input logic [15:0] l1,
                                      input logic [15:0] l2, input logic [15:0] l3);
    logic [23:0] r;
    r = 24'h00_0000;
    otp_locked = 1'b0;
    if (a >= FACT_ID_ADDR && a <= FACT_ID_END)
      otp_locked = ~l1[0];
    else if (a > FACT_ID_END && a <= USER8_END)
      otp_locked = ~l1[1];
    else if (a >= SEG16_ADDR && a <= SEG16_END)
    begin
      r = a - SEG16_ADDR;
      otp_locked = ~l2[r[7:4]];
    end
    else if (a >= SEG3_ADDR && a <= OTP_TOP)
    begin
      r = a - SEG3_ADDR;
      otp_locked = ~l3[r[7:4]];
    end
  endfunction

  // Region grows downward from the top; shift is log2 of the protected fraction's denominator
  function automatic logic main_protected(input logic [23:0] a, input logic [2:0] lvl);
    int sh;
    int unsigned top;
    sh = (DENSITY == DENS_SMALL) ? 6 - int'(lvl) : 7 - int'(lvl);
    top = 0;
    if (lvl == 3'h0)
      main_protected = 1'b0;
    else if (lvl == 3'h7 || sh <= 0)
      main_protected = 1'b1;
    else
    begin
      top = int'(a & ADDR_MASK) >> (AW - sh);
      main_protected = (top == (1 << sh) - 1);
    end
  endfunction

  sfp_spi_in_t pin_s1;
  sfp_spi_in_t pin_s2;
  sfp_spi_in_t pin_s3;
  logic        active;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        byte_done;
  logic [7:0]  in_byte;

  sfp_phase_t  phase;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  cmd;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [1:0]  addr_cnt;
  logic [8:0]  nbytes;
  logic [2:0]  out_bit;
  logic        out_live;
  logic [7:0]  rd_byte;

  logic [7:0]  main_mem [2**MAIN_AW];
  logic [7:0]  otp_mem  [OTP_DEPTH];
  logic [7:0]  page_buf [256];
  logic [15:0] lock1;
  logic [15:0] lock2;
  logic [15:0] lock3;

  logic        sr_lock;
  logic [2:0]  prot_level;
  logic        pfail;
  logic        write_permit_flag;
  logic        busy;
  logic [7:0]  status_byte;
  logic        hw_protect;
  logic        ended;
  logic        do_wren;
  logic        do_wrdi;
  logic        do_clear;
  logic        do_wsr;
  logic        prog_req;
  logic        prog_main;
  logic        prog_denied;
  logic        do_prog;

  sfp_eng_t    eng_state;
  logic [23:0] eng_base;
  logic        eng_otp;
  logic [8:0]  eng_cnt;
  logic [8:0]  eng_idx;
  logic [15:0] wait_cnt;
  logic [23:0] prog_addr;
  logic        eng_done;
  logic        eng_fail;

  logic        apb_acc;
  logic [15:0] busy_cfg;
  logic        pwr_restart;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= SPI_IDLE;
      pin_s2 <= SPI_IDLE;
      pin_s3 <= SPI_IDLE;
    end
    else
    begin
      pin_s1 <= spi_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Serial clock edges are ignored while paused, so the stream freezes in place
  assign active    = ~pin_s2.select_n & pin_s2.pause_n;
  assign sck_rise  = active & pin_s2.sclk & ~pin_s3.sclk;
  assign sck_fall  = active & ~pin_s2.sclk & pin_s3.sclk;
  assign cs_rise   = pin_s2.select_n & ~pin_s3.select_n;
  assign in_byte   = {shift_in[6:0], pin_s2.si};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);
  assign next_addr = (addr + 24'h00_0001) & ADDR_MASK;
  assign busy      = (eng_state != ENG_IDLE);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase    <= PH_CMD;
      bit_cnt  <= 3'h0;
      shift_in <= 8'h00;
      cmd      <= 8'h00;
      addr     <= 24'h00_0000;
      addr_cnt <= 2'h0;
      nbytes   <= 9'h000;
      out_bit  <= 3'h0;
      out_live <= 1'b0;
    end
    else if (pin_s2.select_n)
    begin
      phase    <= PH_CMD;
      bit_cnt  <= 3'h0;
      addr_cnt <= 2'h0;
      nbytes   <= 9'h000;
      out_bit  <= 3'h0;
      out_live <= 1'b0;
    end
    else
    begin
      if (sck_rise)
      begin
        shift_in <= in_byte;
        bit_cnt  <= bit_cnt + 3'h1;
      end
      if (byte_done)
      begin
        case (phase)
          PH_CMD:
          begin
            cmd <= in_byte;
            if (busy && in_byte != CMD_READ_STATUS)
              phase <= PH_IGNORE;
            else if (in_byte == CMD_READ_STATUS)
              phase <= PH_OUT;
            else if (in_byte == CMD_FAST_READ || in_byte == CMD_READ || in_byte == CMD_PAGE_PROG ||
                     in_byte == OTP_PROG_OP || in_byte == OTP_READ_OP)
              phase <= PH_ADDR;
            else
              phase <= PH_DATA;
          end
          PH_ADDR:
          begin
            addr     <= {addr[15:0], in_byte};
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == 2'h2)
            begin
              if (cmd == CMD_READ)
                phase <= PH_OUT;
              else if (cmd == CMD_PAGE_PROG || cmd == OTP_PROG_OP)
                phase <= PH_DATA;
              else
                phase <= PH_DUMMY;
            end
          end
          PH_DUMMY:
            phase <= PH_OUT;
          PH_DATA:
            // Bytes beyond a full buffer are dropped, not wrapped over earlier ones
            if (nbytes != PAGE_BYTES)
              nbytes <= nbytes + 9'h001;
          default:
            ;
        endcase
      end
      if (sck_fall && phase == PH_OUT)
      begin
        out_bit  <= out_bit + 3'h1;
        out_live <= 1'b1;
        if (out_bit == 3'h7 && cmd != CMD_READ_STATUS)
          addr <= next_addr;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (byte_done && phase == PH_DATA && nbytes != PAGE_BYTES)
      page_buf[nbytes[7:0]] <= in_byte;
  end

  assign status_byte = {sr_lock, pfail, 1'b0, prot_level, write_permit_flag, busy};

  always_comb
  begin
    if (cmd == CMD_READ_STATUS)
      rd_byte = status_byte;
    else if (cmd == OTP_READ_OP)
      rd_byte = otp_in_range(addr) ? otp_mem[otp_index(addr)] : ERASED_BYTE;
    else
      rd_byte = main_mem[addr[MAIN_AW-1:0]];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      spi_so <= 1'b0;
    else if (sck_fall && phase == PH_OUT)
      spi_so <= rd_byte[3'h7 - out_bit];
  end

  // Output is released during a pause and comes back with the held bit on resume
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      spi_so_oe <= 1'b0;
    else
      spi_so_oe <= active & (out_live | (sck_fall && phase == PH_OUT));
  end

  assign hw_protect = ~pin_s2.wp_n & sr_lock;
  assign prog_main  = (cmd == CMD_PAGE_PROG);

  always_comb
  begin
    ended       = cs_rise && phase == PH_DATA && bit_cnt == 3'h0;
    do_wren     = ended && cmd == CMD_WRITE_ENABLE && nbytes == 9'h000;
    do_wrdi     = ended && cmd == CMD_WRITE_DISABLE;
    do_clear    = ended && cmd == CMD_CLEAR_FAIL;
    do_wsr      = ended && cmd == CMD_WRITE_STATUS && nbytes != 9'h000 && write_permit_flag && !hw_protect;
    prog_req    = ended && (prog_main || cmd == OTP_PROG_OP) && nbytes != 9'h000 && write_permit_flag;
    prog_denied = prog_req && prog_main && main_protected(addr, prot_level);
    do_prog     = prog_req && (prog_main ? !prog_denied : otp_in_range(addr));
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_lock    <= 1'b0;
      prot_level <= LEVEL_RESET;
    end
    else if (pwr_restart)
    begin
      sr_lock    <= 1'b0;
      prot_level <= LEVEL_RESET;
    end
    else if (do_wsr)
    begin
      sr_lock    <= page_buf[0][SR_LOCK_BIT];
      prot_level <= page_buf[0][SR_LEVEL_HI:SR_LEVEL_LO];
    end
  end

  // A program refused for a protected array region keeps the write permit, as the device stays ready; a locked OTP program clears it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      write_permit_flag <= 1'b0;
    else if (pwr_restart || eng_done || do_wrdi)
      write_permit_flag <= 1'b0;
    else if (do_wren)
      write_permit_flag <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pfail <= 1'b0;
    else if (prog_denied || eng_fail)
      pfail <= 1'b1;
    else if (do_clear || pwr_restart)
      pfail <= 1'b0;
  end

  assign prog_addr = {eng_base[23:8], eng_base[7:0] + eng_idx[7:0]};
  assign eng_done  = (eng_state == ENG_WAIT) && (wait_cnt == 16'h0000);
  assign eng_fail  = (eng_state == ENG_WRITE) && eng_otp && otp_locked(prog_addr, lock1, lock2, lock3);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eng_state <= ENG_IDLE;
      eng_base  <= 24'h00_0000;
      eng_otp   <= 1'b0;
      eng_cnt   <= 9'h000;
      eng_idx   <= 9'h000;
      wait_cnt  <= 16'h0000;
    end
    else
    begin
      case (eng_state)
        ENG_IDLE:
          if (do_prog)
          begin
            eng_base  <= addr;
            eng_otp   <= !prog_main;
            eng_cnt   <= nbytes;
            eng_idx   <= 9'h000;
            eng_state <= ENG_WRITE;
          end
          else if (do_wsr)
          begin
            wait_cnt  <= busy_cfg;
            eng_state <= ENG_WAIT;
          end
        ENG_WRITE:
        begin
          eng_idx <= eng_idx + 9'h001;
          if (eng_idx == eng_cnt - 9'h001)
          begin
            wait_cnt  <= busy_cfg;
            eng_state <= ENG_WAIT;
          end
        end
        ENG_WAIT:
          if (wait_cnt == 16'h0000)
            eng_state <= ENG_IDLE;
          else
            wait_cnt <= wait_cnt - 16'h0001;
        default:
          eng_state <= ENG_IDLE;
      endcase
    end
  end

  // Programming only clears bits; only reset sets a bit back to one
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 2**MAIN_AW; i++)
        main_mem[i] <= ERASED_BYTE;
    end
    else if (eng_state == ENG_WRITE && !eng_otp)
      main_mem[prog_addr[MAIN_AW-1:0]] <= main_mem[prog_addr[MAIN_AW-1:0]] & page_buf[eng_idx[7:0]];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < OTP_DEPTH; i++)
        otp_mem[i] <= ERASED_BYTE;
      for (int i = 0; i < 8; i++)
        otp_mem[otp_index(FACT_ID_ADDR) + 9'(i)] <= FACTORY_ID[8*i +: 8];
      otp_mem[otp_index(LOCK1_ADDR)] <= LOCK1_RESET;
    end
    else if (eng_state == ENG_WRITE && eng_otp && otp_in_range(prog_addr) && !eng_fail)
      otp_mem[otp_index(prog_addr)] <= otp_mem[otp_index(prog_addr)] & page_buf[eng_idx[7:0]];
  end

  assign lock1 = {otp_mem[otp_index(LOCK1_ADDR) + 9'h001], otp_mem[otp_index(LOCK1_ADDR)]};
  assign lock2 = {otp_mem[otp_index(LOCK2_ADDR) + 9'h001], otp_mem[otp_index(LOCK2_ADDR)]};
  assign lock3 = {otp_mem[otp_index(LOCK3_ADDR) + 9'h001], otp_mem[otp_index(LOCK3_ADDR)]};

  // One wait state keeps read data registered; writes land on the edge that sees pready high
  assign apb_acc = apb_req.psel & apb_req.penable;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_acc & ~pready;
      pslverr <= 1'b0;
      if (apb_acc && !pready)
      begin
        case (apb_req.paddr)
          REG_STATUS:   prdata <= {24'h00_0000, status_byte};
          REG_BUSY_CFG: prdata <= {16'h0000, busy_cfg};
          REG_CONTROL:  prdata <= 32'h0000_0000;
          REG_OTP_LOCK: prdata <= {lock2, lock1};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_cfg    <= BUSY_CYCLES;
      pwr_restart <= 1'b0;
    end
    else
    begin
      pwr_restart <= 1'b0;
      if (apb_acc && pready && apb_req.pwrite)
      begin
        if (apb_req.paddr == REG_BUSY_CFG)
          busy_cfg <= apb_req.pwdata[15:0];
        if (apb_req.paddr == REG_CONTROL)
          pwr_restart <= apb_req.pwdata[0];
      end
    end
  end
endmodule

// file: design/sfp_pkg.sv
// Constants, field layouts and carrier types for the serial flash command and protection block.
// Assumes a 20 MHz system clock and an SPI host driving select, clock, data, pause and write-protect pins.
//
// Behaviour
// - Status bits 4:2 choose the protected main-array region; 000 none, 111 all.
// - Largest density: codes 001..110 protect upper 1/64 up to 1/2 of array.
// - Middle density as largest; smallest protects 1/32..1/2, and 110 protects all.
// - Pin low with write-lock bit set refuses writes to bit 7 and bits 4:2.
// - All other pin and lock-bit combinations leave lock bit and level writable.
// - Read data leaves on serial clock falling edges, after the last dummy bit.
// - Address steps after every output byte while select stays low.
// - Pause pin low holds the output stream; high resumes where it stopped.
// - Read address past the top of the device wraps to zero.
// - Select rising ends the instruction and releases the serial output.
// - Program starts only when select rises on a byte boundary; else nothing programs.
// - While busy only the status read is accepted; all else is ignored.
// - Program needs the write-enable command first; ignored with write permit clear.
// - Write enable and configuration commands act on the closing select rise.
// - Separate OTP space with two 8-byte, thirty 16-byte, one 10-byte lockable segments.
// - OTP bytes 0x102..0x109 hold a factory identifier; first lock bit 0 reads zero.
// - OTP program uses the page program protocol, never erases, ignores bad range.
// - OTP read uses the fast read protocol; out-of-range reads return erased bytes (0xFF).
// - First lock register locks OTP 0x102..0x111 permanently.
// - Second lock register locks 0x114..0x213, third locks 0x216..0x2FF.
// - Status bit 0 reads one while program or status write runs.
// - Status bit 6 sets when a program hits protected array or locked OTP.
package sfp_pkg;
  localparam logic [7:0]  CMD_WRITE_STATUS  = 8'h01;
  localparam logic [7:0]  CMD_PAGE_PROG     = 8'h02;
  localparam logic [7:0]  CMD_READ          = 8'h03;
  localparam logic [7:0]  CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0]  CMD_READ_STATUS   = 8'h05;
  localparam logic [7:0]  CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0]  CMD_FAST_READ     = 8'h0B;
  localparam logic [7:0]  CMD_CLEAR_FAIL    = 8'h30;
  localparam int          SR_LOCK_BIT       = 7;
  localparam int          SR_LEVEL_HI       = 4;
  localparam int          SR_LEVEL_LO       = 2;
  localparam logic [2:0]  LEVEL_RESET       = 3'h7;
  localparam int          DENS_SMALL        = 0;
  localparam int          DENS_MID          = 1;
  localparam int          DENS_LARGE        = 2;
  localparam int          ADDR_W_SMALL      = 21;
  localparam int          ADDR_W_MID        = 22;
  localparam int          ADDR_W_LARGE      = 23;
  localparam logic [8:0]  PAGE_BYTES        = 9'h100;
  localparam logic [23:0] OTP_BASE          = 24'h00_0100;
  localparam logic [23:0] OTP_TOP           = 24'h00_02FF;
  localparam logic [23:0] LOCK1_ADDR        = 24'h00_0100;
  localparam logic [23:0] LOCK2_ADDR        = 24'h00_0112;
  localparam logic [23:0] LOCK3_ADDR        = 24'h00_0214;
  localparam logic [23:0] FACT_ID_ADDR      = 24'h00_0102;
  localparam logic [23:0] FACT_ID_END       = 24'h00_0109;
  localparam logic [23:0] USER8_END         = 24'h00_0111;
  localparam logic [23:0] SEG16_ADDR        = 24'h00_0114;
  localparam logic [23:0] SEG16_END         = 24'h00_0213;
  localparam logic [23:0] SEG3_ADDR         = 24'h00_0216;
  localparam logic [7:0]  LOCK1_RESET       = 8'hFE;
  localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
  localparam logic [11:0] REG_STATUS        = 12'h000;
  localparam logic [11:0] REG_BUSY_CFG      = 12'h004;
  localparam logic [11:0] REG_CONTROL       = 12'h008;
  localparam logic [11:0] REG_OTP_LOCK      = 12'h00C;
  localparam int          SYS_PERIOD_NS     = 50;
  localparam int          BUSY_TIME_NS      = 10000;
  localparam logic [15:0] BUSY_CYCLES       = 16'((BUSY_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  typedef struct packed {
    logic select_n;
    logic sclk;
    logic si;
    logic pause_n;
    logic wp_n;
  } sfp_spi_in_t;

  localparam sfp_spi_in_t SPI_IDLE = 5'h13;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sfp_apb_req_t;

  typedef enum logic [5:0] {
    PH_CMD    = 6'h01,
    PH_ADDR   = 6'h02,
    PH_DUMMY  = 6'h04,
    PH_OUT    = 6'h08,
    PH_DATA   = 6'h10,
    PH_IGNORE = 6'h20
  } sfp_phase_t;

  typedef enum logic [2:0] {
    ENG_IDLE  = 3'h1,
    ENG_WRITE = 3'h2,
    ENG_WAIT  = 3'h4
  } sfp_eng_t;
endpackage

// file: testbench/sfp_flash_sva.sv
// Checker for the flash block pins: serial output timing, release and APB handshake.
// Assumes SPI pins are sampled by sys_clk through a 2-flop synchroniser inside the block.
`timescale 1ns/1ps
module sfp_flash_sva (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input sfp_pkg::sfp_spi_in_t  spi_in,
  input wire logic             spi_so,
  input wire logic             spi_so_oe,
  input sfp_pkg::sfp_apb_req_t apb_req,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr
);
  import sfp_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_sel_rise;
    $rose(spi_in.select_n);
  endsequence
  sequence s_pause_held;
    $fell(spi_in.pause_n) ##1 !spi_in.pause_n [*5];
  endsequence
  a_oe_release: assert property (s_sel_rise |-> ##[1:5] !spi_so_oe)
    else $error("serial output still driven after select rose");
  a_oe_idle: assert property (spi_in.select_n [*8] |-> !spi_so_oe)
    else $error("serial output driven while deselected");
  a_pause_hold: assert property (s_pause_held |-> !spi_so_oe)
    else $error("serial output driven during pause");
  a_oe_start: assert property ($rose(spi_so_oe) |-> !spi_in.select_n && spi_in.pause_n && !$past(spi_in.sclk, 2))
    else $error("serial output enabled at a wrong moment");
  a_so_on_fall: assert property (spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> !$past(spi_in.sclk, 2))
    else $error("serial output changed away from a falling clock");
  a_apb_wait: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_cause: assert property ($rose(pready) |-> $past(apb_req.psel && apb_req.penable))
    else $error("pready without an access phase");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response without pready or with data");
endmodule

bind sfp_flash_top sfp_flash_sva u_sva (
  .sys_clk   (sys_clk),
  .rst_n     (rst_n),
  .spi_in    (spi_in),
  .spi_so    (spi_so),
  .spi_so_oe (spi_so_oe),
  .apb_req   (apb_req),
  .prdata    (prdata),
  .pready    (pready),
  .pslverr   (pslverr)
);

// file: testbench/sfp_host_model.sv
// SPI host model: mode 0 frames with a 400 ns link clock made from sys_clk.
// Assumes the bench resolves the serial output wire and fills tx_q before calling frame.
`timescale 1ns/1ps
module sfp_host_model (
  input  wire logic            sys_clk,
  input  wire logic            so_wire,
  output sfp_pkg::sfp_spi_in_t spi_in
);
  import sfp_pkg::*;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial spi_in = SPI_IDLE;
  task automatic half();
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic bit_out(input logic v);
    spi_in.si <= v;
    half();
    spi_in.sclk <= 1'b1;
    half();
    spi_in.sclk <= 1'b0;
  endtask
  task automatic set_wp(input logic v);
    spi_in.wp_n <= v;
    half();
  endtask
  task automatic frame(input int nrd, input int extra, input int pz);
    logic [7:0] b;
    rx_q.delete();
    spi_in.select_n <= 1'b0;
    foreach (tx_q[k])
      for (int i = 7; i >= 0; i--)
        bit_out(tx_q[k][i]);
    repeat (extra) bit_out(1'b1);
    for (int k = 0; k < nrd; k++)
    begin
      if (k == pz)
      begin
        // Let the block see the last fall first, so the next bit is already launched
        half();
        spi_in.pause_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        spi_in.pause_n <= 1'b1;
        half();
      end
      for (int i = 7; i >= 0; i--)
      begin
        half();
        spi_in.sclk <= 1'b1;
        half();
        // Sampled late in the high phase: data stands until the next fall
        b[i] = so_wire;
        spi_in.sclk <= 1'b0;
      end
      rx_q.push_back(b);
    end
    half();
    spi_in.select_n <= 1'b1;
    half();
    half();
  endtask
endmodule

// file: testbench/serial_flash_protect_cmd_tb_top.sv
// Bench for the flash command block: APB status checks and SPI host traffic via the host model.
// Assumes sfp_pkg, the checker with its bind and the host model are compiled first.
`timescale 1ns/1ps
module serial_flash_protect_cmd_tb_top;
  import sfp_pkg::*;
  localparam logic [63:0] FID     = 64'h0011_2233_4455_6677; // Arbitrary value
  localparam logic [7:0]  OTP_PRG = 8'h42;
  localparam logic [7:0]  OTP_RD  = 8'h4B;
  logic         sys_clk;
  logic         rst_n;
  sfp_spi_in_t  spi_in;
  logic         spi_so;
  logic         spi_so_oe;
  logic         last_so = 1'b0;
  // Undriven wire shows the inverse of its last value, never a stale copy
  wire          so_wire = spi_so_oe ? spi_so : ~last_so;
  sfp_apb_req_t apb_req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  q;
  logic         e;
  logic [7:0]   ex[$];
  logic [23:0]  lo;
  int           num_errors = 0;
  int           comparisons = 0;
  int           cycles = 0;
  sfp_flash_top #(.FACTORY_ID(FID), .OTP_PROG_OP(OTP_PRG), .OTP_READ_OP(OTP_RD)) dut (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .spi_in    (spi_in),
    .spi_so    (spi_so),
    .spi_so_oe (spi_so_oe),
    .apb_req   (apb_req),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr)
  );
  sfp_host_model host (
    .sys_clk (sys_clk),
    .so_wire (so_wire),
    .spi_in  (spi_in)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    last_so <= so_wire;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic st(input logic [31:0] exp);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic idle();
    do
      apb(1'b0, REG_STATUS, 32'h0000_0000);
    while (q[0] !== 1'b0);
  endtask
  task automatic spi(input logic [7:0] b[$], input int nrd = 0, input int extra = 0, input int pz = -1);
    host.tx_q = b;
    host.frame(nrd, extra, pz);
  endtask
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d[$], input int extra = 0);
    logic [7:0] f[$];
    f = '{op, a[23:16], a[15:8], a[7:0]};
    spi('{CMD_WRITE_ENABLE});
    spi({f, d}, 0, extra);
  endtask
  task automatic wrsr(input logic [7:0] v);
    spi('{CMD_WRITE_ENABLE});
    spi('{CMD_WRITE_STATUS, v});
    idle();
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] x[$], input int pz = -1);
    spi('{op, a[23:16], a[15:8], a[7:0], 8'h00}, x.size(), 0, pz);
    foreach (x[i]) chk(host.rx_q[i], x[i]);
  endtask
  initial
  begin
    rst_n = 1'b0;
    apb_req = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    st(32'h0000_001C);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b1, REG_BUSY_CFG, 32'h0000_012C);
    apb(1'b0, REG_BUSY_CFG, 32'h0000_0000);
    chk(q, 32'h0000_012C);
    $display("test registers done");
    spi('{CMD_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h5A});
    st(32'h0000_001C);
    wrsr(8'h00);
    st(32'h0000_0000);
    prog(CMD_PAGE_PROG, 24'h00_0000, '{8'h5A, 8'hA5});
    st(32'h0000_0003);
    spi('{CMD_WRITE_ENABLE});
    idle();
    st(32'h0000_0000);
    rd(CMD_FAST_READ, 24'h7F_FFFF, '{8'hFF, 8'h5A, 8'hA5}, 1);
    spi('{CMD_READ, 8'h00, 8'h00, 8'h00}, 2);
    chk({host.rx_q[0], host.rx_q[1]}, 32'h0000_5AA5);
    prog(CMD_PAGE_PROG, 24'h00_0002, '{8'h00}, 3);
    st(32'h0000_0002);
    spi('{CMD_WRITE_DISABLE});
    st(32'h0000_0000);
    $display("test program and read done");
    wrsr(8'h9C);
    host.set_wp(1'b0);
    wrsr(8'h00);
    st(32'h0000_009E);
    spi('{CMD_READ_STATUS}, 1);
    chk(host.rx_q[0], 32'h0000_009E);
    host.set_wp(1'b1);
    wrsr(8'h00);
    st(32'h0000_0000);
    $display("test protect modes done");
    for (int c = 1; c < 7; c++)
    begin
      lo = 24'h80_0000 - (24'h80_0000 >> (7 - c));
      wrsr(8'(c << 2));
      prog(CMD_PAGE_PROG, lo, '{8'h00});
      st(32'h0000_0042 | 32'(c << 2));
      spi('{CMD_CLEAR_FAIL});
      prog(CMD_PAGE_PROG, lo - 24'h1, '{8'h00});
      idle();
      st(32'(c << 2));
    end
    $display("test protect levels done");
    ex = '{8'hFE, 8'hFF};
    for (int i = 0; i < 8; i++) ex.push_back(FID[8*i +: 8]);
    rd(OTP_RD, 24'h00_0100, ex);
    prog(OTP_PRG, 24'h00_0102, '{8'h00});
    idle();
    st(32'h0000_0058);
    spi('{CMD_CLEAR_FAIL});
    prog(OTP_PRG, 24'h00_010A, '{8'h12});
    idle();
    prog(OTP_PRG, 24'h00_0100, '{8'hFD});
    idle();
    prog(OTP_PRG, 24'h00_010A, '{8'h00});
    idle();
    st(32'h0000_0058);
    rd(OTP_RD, 24'h00_0108, '{FID[55:48], FID[63:56], 8'h12});
    prog(OTP_PRG, 24'h00_0300, '{8'h00});
    st(32'h0000_005A);
    prog(OTP_PRG, 24'h00_0112, '{8'hFE});
    idle();
    prog(OTP_PRG, 24'h00_0114, '{8'h00});
    idle();
    apb(1'b0, REG_OTP_LOCK, 32'h0000_0000);
    chk(q, 32'hFFFE_FFFC);
    rd(OTP_RD, 24'h00_0114, '{8'hFF});
    apb(1'b1, REG_CONTROL, 32'h0000_0001);
    st(32'h0000_001C);
    $display("test otp done");
    report_and_stop();
  end
endmodule
